// >>> verilog/hfp_pkg.sv
// Purpose: shared constants and types for the host and frame memory port
// Assumes: one 40 MHz clock, synchronous active high reset
// Notes:   no timescale here, packages carry none
package hfp_pkg;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int REG_COUNT = 16;
  localparam int REG_SEL_W = 4;
  localparam int CS_COUNT  = 5;
  localparam int CHIP_LIM  = 8;

  // memory size strap codes
  localparam logic MEM_8K  = 1'b0;
  localparam logic MEM_32K = 1'b1;

  // bus width strap codes
  localparam logic WIDTH_8  = 1'b0;
  localparam logic WIDTH_16 = 1'b1;

  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [15:0] BUS_IDLE  = 16'hFFFF;
  localparam logic [7:0]  BYTE_IDLE = 8'hFF;

  // timing
  localparam int MCLK_KHZ         = 40000;
  localparam int SLOT_NS          = 50;
  localparam int SLOT_CYCLES      = (SLOT_NS * MCLK_KHZ + 999999) / 1000000;
  localparam int PCLK_HALF_NS     = 50;
  localparam int PCLK_HALF_CYCLES = (PCLK_HALF_NS * MCLK_KHZ + 999999) / 1000000;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_REG_WR = 3'b001,
    OP_REG_RD = 3'b010,
    OP_MEM_WR = 3'b011,
    OP_MEM_RD = 3'b100,
    OP_ERROR  = 3'b101
  } hfp_op_t;

  // byte lanes {high, low} used by one access
  function automatic logic [1:0] hfp_lanes(input logic wide, input logic a0, input logic bhe_n);
    logic [1:0] m;
    m = 2'b01;
    if (wide == WIDTH_16) begin
      if (a0)
        m = 2'b10;
      else if (!bhe_n)
        m = 2'b11;
    end
    return m;
  endfunction
endpackage

// >>> verilog/hfp_link_if.sv
// Purpose: processor side pins joining the host end and the device end
// Assumes: data bus resolved here from the two output enables
// Notes:   an undriven data bus reads as all ones
`timescale 1ns/100ps
interface hfp_link_if (
  input wire logic mclk_i
);
  logic [15:0] host_address_bus;
  logic [15:0] host_data_out;
  logic        host_data_oe;
  logic [15:0] dev_data_out;
  logic        dev_data_oe;
  logic [15:0] host_data_bus;
  logic        high_byte_enable;
  logic        register_chip_select_n;
  logic        register_write_strobe_n;
  logic        register_read_strobe_n;
  logic        frame_memory_select_n;
  logic        frame_memory_write_strobe_n;
  logic        frame_memory_read_strobe_n;
  logic        processor_clock_in;
  logic        bus_width_strap;
  logic        ready;

  assign host_data_bus = host_data_oe ? host_data_out :
                         dev_data_oe  ? dev_data_out  : hfp_pkg::BUS_IDLE;

  modport device (
    input  host_address_bus, host_data_bus, high_byte_enable,
    input  register_chip_select_n, register_write_strobe_n, register_read_strobe_n,
    input  frame_memory_select_n, frame_memory_write_strobe_n, frame_memory_read_strobe_n,
    input  processor_clock_in, bus_width_strap,
    output dev_data_out, dev_data_oe, ready
  );

  modport host (
    output host_address_bus, host_data_out, host_data_oe, high_byte_enable,
    output register_chip_select_n, register_write_strobe_n, register_read_strobe_n,
    output frame_memory_select_n, frame_memory_write_strobe_n, frame_memory_read_strobe_n,
    output processor_clock_in, bus_width_strap,
    input  host_data_bus, ready
  );
endinterface

// >>> verilog/hfp_ctrl_decode.sv
// Purpose: classify the six processor control pins into one operation
// Assumes: all pins active low
// Notes:   purely combinational
`timescale 1ns/100ps
module hfp_ctrl_decode (
  // control pins
  input  wire logic           reg_cs_n_i,
  input  wire logic           reg_wr_n_i,
  input  wire logic           reg_rd_n_i,
  input  wire logic           mem_cs_n_i,
  input  wire logic           mem_wr_n_i,
  input  wire logic           mem_rd_n_i,
  // result
  output hfp_pkg::hfp_op_t    op_o
);
  always_comb begin
    case ({reg_cs_n_i, reg_wr_n_i, reg_rd_n_i, mem_cs_n_i, mem_wr_n_i, mem_rd_n_i})
      6'b001111: op_o = hfp_pkg::OP_REG_WR;
      6'b010111: op_o = hfp_pkg::OP_REG_RD;
      6'b111001: op_o = hfp_pkg::OP_MEM_WR;
      6'b111010: op_o = hfp_pkg::OP_MEM_RD;
      default: begin
        // both selects high is no access, anything else is a fault
        if (reg_cs_n_i && mem_cs_n_i)
          op_o = hfp_pkg::OP_NONE;
        else
          op_o = hfp_pkg::OP_ERROR;
      end
    endcase
  end
endmodule

// >>> verilog/hfp_device_port.sv
// Purpose: device end: control registers, wait pin, cycle stealing frame memory port
// Assumes: processor pins synchronous to mclk_i; display fetches arrive on the user side
// Notes:   one write enable serves both lanes; byte writes rely on the lane output enables only
`timescale 1ns/100ps
module hfp_device_port (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    reset_i,
  // processor side
  hfp_link_if.device                   link,
  // frame memory pins
  input  wire logic                    mem_size_strap_i,
  output logic      [15:0]             frame_memory_address_o,
  output logic      [4:0]              frame_memory_chip_selects_o,
  output logic                         frame_memory_write_enable_n_o,
  input  wire logic [15:0]             frame_memory_data_i,
  output logic      [15:0]             frame_memory_data_o,
  output logic      [1:0]              frame_memory_data_oe_o,
  // display fetch side
  input  wire logic                    fetch_req_i,
  input  wire logic [15:0]             fetch_addr_i,
  output logic                         fetch_done_o,
  output logic      [15:0]             fetch_data_o,
  // status and control
  output logic      [15:0][7:0]        ctrl_regs_o,
  output logic                         bus_error_o
);
  typedef enum logic [2:0] {
    H_IDLE     = 3'b000,
    H_REG      = 3'b001,
    H_MEM_WAIT = 3'b010,
    H_DONE     = 3'b011,
    H_HOLD     = 3'b100
  } hfp_hstate_t;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_FETCH = 2'b01,
    M_HOST  = 2'b10
  } hfp_mstate_t;

  hfp_hstate_t       hstate;
  hfp_mstate_t       mstate;
  hfp_pkg::hfp_op_t  op_now;
  hfp_pkg::hfp_op_t  op_q;
  logic [15:0]       addr_q;
  logic [15:0]       wdata_q;
  logic [1:0]        lanes_q;
  logic              host_req;
  logic              mem_done;
  logic              pclk_prev;
  logic              pclk_rise;
  logic              sel_any;
  logic [7:0]        slot_cnt;
  logic [15:0]       next_addr;
  logic [4:0]        next_cs;
  logic [3:0]        reg_lo;
  logic [3:0]        reg_hi;

  localparam logic [7:0] SLOT_LAST = 8'(hfp_pkg::SLOT_CYCLES - 1);

  // chip selects, with the top address lines doubling as selects in 8K mode
  function automatic logic [20:0] cs_map(input logic size32, input logic [15:0] a);
    logic [7:0]  one_n;
    logic [15:0] pins;
    one_n = 8'hFF;
    pins  = a;
    if (size32) begin
      one_n[a[15]] = 1'b0;
    end else begin
      one_n[a[15:13]] = 1'b0;
      pins[13] = one_n[7];
      pins[14] = one_n[6];
      pins[15] = one_n[5];
    end
    return {one_n[4:0], pins};
  endfunction

  hfp_ctrl_decode u_decode (
    .reg_cs_n_i (link.register_chip_select_n),
    .reg_wr_n_i (link.register_write_strobe_n),
    .reg_rd_n_i (link.register_read_strobe_n),
    .mem_cs_n_i (link.frame_memory_select_n),
    .mem_wr_n_i (link.frame_memory_write_strobe_n),
    .mem_rd_n_i (link.frame_memory_read_strobe_n),
    .op_o       (op_now)
  );

  assign sel_any   = !link.register_chip_select_n || !link.frame_memory_select_n;
  assign pclk_rise = link.processor_clock_in && !pclk_prev;
  // combinational so it falls in the very cycle a select drops
  assign link.ready = !sel_any || (hstate == H_HOLD);
  assign reg_lo = (lanes_q == 2'b11) ? {addr_q[3:1], 1'b0} : addr_q[3:0];
  assign reg_hi = (lanes_q == 2'b11) ? {addr_q[3:1], 1'b1} : addr_q[3:0];

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      pclk_prev <= 1'b0;
    else
      pclk_prev <= link.processor_clock_in;
  end

  // processor access sequencing
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hstate   <= H_IDLE;
      op_q     <= hfp_pkg::OP_NONE;
      addr_q   <= 16'h0000;
      wdata_q  <= 16'h0000;
      lanes_q  <= 2'b01;
      host_req <= 1'b0;
    end else begin
      case (hstate)
        H_IDLE: begin
          op_q    <= op_now;
          addr_q  <= link.host_address_bus;
          wdata_q <= link.host_data_bus;
          lanes_q <= hfp_pkg::hfp_lanes(link.bus_width_strap, link.host_address_bus[0],
                                        link.high_byte_enable);
          case (op_now)
            hfp_pkg::OP_REG_WR, hfp_pkg::OP_REG_RD: hstate <= H_REG;
            hfp_pkg::OP_MEM_WR, hfp_pkg::OP_MEM_RD: begin
              host_req <= 1'b1;
              hstate   <= H_MEM_WAIT;
            end
            // a fault still ends the wait so the host cannot hang
            hfp_pkg::OP_ERROR: hstate <= H_DONE;
            default: hstate <= H_IDLE;
          endcase
        end
        H_REG: hstate <= H_DONE;
        H_MEM_WAIT: begin
          if (mem_done) begin
            host_req <= 1'b0;
            hstate   <= H_DONE;
          end
        end
        H_DONE: begin
          if (pclk_rise)
            hstate <= H_HOLD;
        end
        H_HOLD: begin
          if (!sel_any)
            hstate <= H_IDLE;
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end

  // control registers and their read data
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_regs_o <= {hfp_pkg::REG_COUNT{hfp_pkg::REG_RESET}};
    end else if (hstate == H_REG && op_q == hfp_pkg::OP_REG_WR) begin
      if (lanes_q[0])
        ctrl_regs_o[reg_lo] <= wdata_q[7:0];
      if (lanes_q[1])
        ctrl_regs_o[reg_hi] <= wdata_q[15:8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      link.dev_data_out <= hfp_pkg::BUS_IDLE;
    end else if (hstate == H_REG && op_q == hfp_pkg::OP_REG_RD) begin
      link.dev_data_out <= {ctrl_regs_o[reg_hi], ctrl_regs_o[reg_lo]};
    end else if (mstate == M_HOST && slot_cnt == SLOT_LAST && op_q == hfp_pkg::OP_MEM_RD) begin
      link.dev_data_out <= frame_memory_data_i;
    end
  end

  // read data stands from the end of the work until the selects rise
  assign link.dev_data_oe = (hstate == H_DONE || hstate == H_HOLD) &&
                            (op_q == hfp_pkg::OP_REG_RD || op_q == hfp_pkg::OP_MEM_RD);

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      bus_error_o <= 1'b0;
    else if (hstate == H_IDLE && op_now == hfp_pkg::OP_ERROR)
      bus_error_o <= 1'b1;
  end

  // memory slot arbiter: display fetch first, host steals free slots
  assign {next_cs, next_addr} = cs_map(mem_size_strap_i, fetch_req_i ? fetch_addr_i : addr_q);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mstate                        <= M_IDLE;
      slot_cnt                      <= 8'h00;
      mem_done                      <= 1'b0;
      fetch_done_o                  <= 1'b0;
      fetch_data_o                  <= 16'h0000;
      frame_memory_address_o        <= 16'h0000;
      frame_memory_chip_selects_o   <= 5'h1F;
      frame_memory_write_enable_n_o <= 1'b1;
      frame_memory_data_o           <= hfp_pkg::BUS_IDLE;
      frame_memory_data_oe_o        <= 2'b00;
    end else begin
      mem_done     <= 1'b0;
      fetch_done_o <= 1'b0;
      case (mstate)
        M_IDLE: begin
          slot_cnt <= 8'h00;
          if (fetch_req_i || (host_req && !mem_done)) begin
            mstate                      <= fetch_req_i ? M_FETCH : M_HOST;
            frame_memory_address_o      <= next_addr;
            frame_memory_chip_selects_o <= next_cs;
            if (!fetch_req_i && op_q == hfp_pkg::OP_MEM_WR) begin
              frame_memory_write_enable_n_o <= 1'b0;
              frame_memory_data_o           <= wdata_q;
              // upper lane left to its tie in a narrow system
              frame_memory_data_oe_o        <= lanes_q;
            end
          end
        end
        M_FETCH, M_HOST: begin
          slot_cnt                      <= slot_cnt + 8'h01;
          frame_memory_write_enable_n_o <= 1'b1;
          if (slot_cnt == SLOT_LAST) begin
            mstate                      <= M_IDLE;
            frame_memory_chip_selects_o <= 5'h1F;
            frame_memory_data_oe_o      <= 2'b00;
            if (mstate == M_FETCH) begin
              fetch_done_o <= 1'b1;
              fetch_data_o <= frame_memory_data_i;
            end else begin
              mem_done <= 1'b1;
            end
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end
endmodule

// >>> verilog/hfp_host_port.sv
// Purpose: processor end: turns user commands into select and strobe sequences
// Assumes: device answers through the ready pin
// Notes:   makes the processor clock by dividing mclk_i
`timescale 1ns/100ps
module hfp_host_port (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // device side
  hfp_link_if.host               link,
  // configuration
  input  wire logic              width_16_i,
  // command
  input  wire logic              cmd_valid_i,
  input  hfp_pkg::hfp_op_t       cmd_kind_i,
  input  wire logic [15:0]       cmd_addr_i,
  input  wire logic              cmd_word_i,
  input  wire logic [15:0]       cmd_data_i,
  output logic                   cmd_ready_o,
  // response
  output logic                   rsp_valid_o,
  output logic [15:0]            rsp_data_o
);
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_ASSERT = 2'b01,
    S_WAIT   = 2'b10,
    S_END    = 2'b11
  } hfp_sstate_t;

  hfp_sstate_t      state;
  hfp_pkg::hfp_op_t kind_q;
  logic [7:0]       div_cnt;

  localparam logic [7:0] DIV_LAST = 8'(hfp_pkg::PCLK_HALF_CYCLES - 1);

  assign cmd_ready_o          = (state == S_IDLE);
  assign link.bus_width_strap = width_16_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      div_cnt                 <= 8'h00;
      link.processor_clock_in <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt                 <= 8'h00;
      link.processor_clock_in <= !link.processor_clock_in;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state                            <= S_IDLE;
      kind_q                           <= hfp_pkg::OP_NONE;
      rsp_valid_o                      <= 1'b0;
      rsp_data_o                       <= 16'h0000;
      link.host_address_bus            <= 16'h0000;
      link.host_data_out               <= hfp_pkg::BUS_IDLE;
      link.host_data_oe                <= 1'b0;
      link.high_byte_enable            <= 1'b1;
      link.register_chip_select_n      <= 1'b1;
      link.register_write_strobe_n     <= 1'b1;
      link.register_read_strobe_n      <= 1'b1;
      link.frame_memory_select_n       <= 1'b1;
      link.frame_memory_write_strobe_n <= 1'b1;
      link.frame_memory_read_strobe_n  <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid_i && (cmd_kind_i == hfp_pkg::OP_REG_WR || cmd_kind_i == hfp_pkg::OP_REG_RD ||
                              cmd_kind_i == hfp_pkg::OP_MEM_WR || cmd_kind_i == hfp_pkg::OP_MEM_RD)) begin
            state                 <= S_ASSERT;
            kind_q                <= cmd_kind_i;
            link.host_address_bus <= cmd_addr_i;
            // low for odd bytes and even words, tied high when narrow
            link.high_byte_enable <= !(width_16_i && (cmd_addr_i[0] || cmd_word_i));
            link.host_data_out    <= width_16_i ? cmd_data_i
                                                : {hfp_pkg::BYTE_IDLE, cmd_data_i[7:0]};
            link.host_data_oe     <= (cmd_kind_i == hfp_pkg::OP_REG_WR || cmd_kind_i == hfp_pkg::OP_MEM_WR);
          end
        end
        S_ASSERT: begin
          state <= S_WAIT;
          link.register_chip_select_n      <= !(kind_q == hfp_pkg::OP_REG_WR || kind_q == hfp_pkg::OP_REG_RD);
          link.register_write_strobe_n     <= !(kind_q == hfp_pkg::OP_REG_WR);
          link.register_read_strobe_n      <= !(kind_q == hfp_pkg::OP_REG_RD);
          link.frame_memory_select_n       <= !(kind_q == hfp_pkg::OP_MEM_WR || kind_q == hfp_pkg::OP_MEM_RD);
          link.frame_memory_write_strobe_n <= !(kind_q == hfp_pkg::OP_MEM_WR);
          link.frame_memory_read_strobe_n  <= !(kind_q == hfp_pkg::OP_MEM_RD);
        end
        S_WAIT: begin
          // ready wired straight in, no pull-up assumed
          if (link.ready) begin
            state                            <= S_END;
            rsp_valid_o                      <= 1'b1;
            rsp_data_o                       <= link.host_data_bus;
            link.host_data_oe                <= 1'b0;
            link.register_chip_select_n      <= 1'b1;
            link.register_write_strobe_n     <= 1'b1;
            link.register_read_strobe_n      <= 1'b1;
            link.frame_memory_select_n       <= 1'b1;
            link.frame_memory_write_strobe_n <= 1'b1;
            link.frame_memory_read_strobe_n  <= 1'b1;
          end
        end
        S_END: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> verification/hfp_link_chk.sv
// Purpose: pin checks between the host end and the device end
// Assumes: one clock, synchronous active high reset
// Notes:   watches only, drives nothing
`timescale 1ns/100ps
module hfp_link_chk (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_i,
  // controls
  input wire logic        ready,
  input wire logic        processor_clock_in,
  input wire logic        register_chip_select_n,
  input wire logic        register_write_strobe_n,
  input wire logic        register_read_strobe_n,
  input wire logic        frame_memory_select_n,
  input wire logic        frame_memory_write_strobe_n,
  input wire logic        frame_memory_read_strobe_n,
  input wire logic        high_byte_enable,
  input wire logic        bus_width_strap,
  // buses
  input wire logic [15:0] host_address_bus,
  input wire logic        host_data_oe,
  input wire logic        dev_data_oe
);
  logic idle;
  assign idle = register_chip_select_n && frame_memory_select_n;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wait_low_a: assert property ($fell(idle) |-> !ready)
    else $error("wait not asserted on select");
  wait_release_a: assert property ($rose(ready) && !idle |-> processor_clock_in || $past(processor_clock_in))
    else $error("wait released off processor clock");
  idle_ready_a: assert property (idle |-> ready)
    else $error("wait low with no access");
  // bounded so a hung steal shows up as a failure
  wait_bound_a: assert property ($fell(idle) |-> ##[1:300] ready)
    else $error("wait never released");
  pins_hold_a: assert property (!idle && !ready |=> !idle && $stable(host_address_bus))
    else $error("access dropped during wait");
  reg_combo_a: assert property (!register_chip_select_n |-> frame_memory_select_n &&
    frame_memory_write_strobe_n && frame_memory_read_strobe_n && (register_write_strobe_n != register_read_strobe_n))
    else $error("illegal register combination");
  mem_combo_a: assert property (!frame_memory_select_n |-> register_chip_select_n &&
    register_write_strobe_n && register_read_strobe_n && (frame_memory_write_strobe_n != frame_memory_read_strobe_n))
    else $error("illegal memory combination");
  narrow_bhe_a: assert property (!bus_width_strap && !idle |-> high_byte_enable)
    else $error("byte enable low on narrow bus");
  odd_bhe_a: assert property (bus_width_strap && !idle && host_address_bus[0] |-> !high_byte_enable)
    else $error("byte enable high on odd address");
  read_drive_a: assert property (dev_data_oe |-> !host_data_oe &&
    !($past(register_read_strobe_n) && $past(frame_memory_read_strobe_n)))
    else $error("device drives bus outside a read");
  cover property (!register_write_strobe_n && $rose(ready));
  cover property (!frame_memory_read_strobe_n && $rose(ready));
  cover property (!bus_width_strap && !frame_memory_select_n);
endmodule

// >>> verification/tb.sv
// Purpose: end to end bench for host end and device end
// Assumes: memory model keyed by address pins, fetches compete for slots
// Notes:   byte lanes of odd 16-bit accesses are not probed
`timescale 1ns/100ps
module tb;
  logic                mclk_i = 1'b0;
  logic                reset_i = 1'b1;
  logic                width_16 = 1'b1;
  logic                mem_size = 1'b1;
  logic                cmd_valid = 1'b0;
  hfp_pkg::hfp_op_t    cmd_kind = hfp_pkg::OP_NONE;
  logic [15:0]         cmd_addr = 16'h0000;
  logic                cmd_word = 1'b0;
  logic [15:0]         cmd_data = 16'h0000;
  logic                fetch_req = 1'b0;
  logic [15:0]         fetch_addr = 16'h0000;
  logic                cmd_ready, rsp_valid, fetch_done, fm_we_n, bus_error, sel;
  logic [15:0]         rsp_data, fm_addr, fm_din, fm_dout, fetch_data, rd, last_a;
  logic [4:0]          fm_cs, last_cs;
  logic [1:0]          fm_oe;
  logic [15:0][7:0]    ctrl_regs;
  logic [7:0]          lo_m [65536];
  logic [7:0]          hi_m [65536];
  int                  miscompares = 0;
  int                  total_checks = 0;
  int                  cyc = 0;

  always #12.5 mclk_i = ~mclk_i;

  hfp_link_if i_hfp_link_if (.mclk_i(mclk_i));
  hfp_device_port i_hfp_device_port (.mclk_i(mclk_i), .reset_i(reset_i), .link(i_hfp_link_if),
    .mem_size_strap_i(mem_size), .frame_memory_address_o(fm_addr), .frame_memory_chip_selects_o(fm_cs),
    .frame_memory_write_enable_n_o(fm_we_n), .frame_memory_data_i(fm_din), .frame_memory_data_o(fm_dout),
    .frame_memory_data_oe_o(fm_oe), .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
    .fetch_done_o(fetch_done), .fetch_data_o(fetch_data), .ctrl_regs_o(ctrl_regs), .bus_error_o(bus_error));
  hfp_host_port i_hfp_host_port (.mclk_i(mclk_i), .reset_i(reset_i), .link(i_hfp_link_if),
    .width_16_i(width_16), .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr),
    .cmd_word_i(cmd_word), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  hfp_link_chk i_hfp_link_chk (.mclk_i(mclk_i), .reset_i(reset_i), .ready(i_hfp_link_if.ready),
    .processor_clock_in(i_hfp_link_if.processor_clock_in),
    .register_chip_select_n(i_hfp_link_if.register_chip_select_n),
    .register_write_strobe_n(i_hfp_link_if.register_write_strobe_n),
    .register_read_strobe_n(i_hfp_link_if.register_read_strobe_n),
    .frame_memory_select_n(i_hfp_link_if.frame_memory_select_n),
    .frame_memory_write_strobe_n(i_hfp_link_if.frame_memory_write_strobe_n),
    .frame_memory_read_strobe_n(i_hfp_link_if.frame_memory_read_strobe_n),
    .high_byte_enable(i_hfp_link_if.high_byte_enable), .bus_width_strap(i_hfp_link_if.bus_width_strap),
    .host_address_bus(i_hfp_link_if.host_address_bus), .host_data_oe(i_hfp_link_if.host_data_oe),
    .dev_data_oe(i_hfp_link_if.dev_data_oe));

  // memory model: unselected or writing, the bus shows a moving pattern
  assign sel = (fm_cs != 5'h1F) || (!mem_size && fm_addr[15:13] != 3'b111);
  assign fm_din = (sel && fm_we_n && fm_oe == 2'b00) ?
    {width_16 ? hi_m[fm_addr] : 8'hFF, lo_m[fm_addr]} : ~cyc[15:0];
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (!fm_we_n && sel) begin
      last_a <= fm_addr;
      last_cs <= fm_cs;
      if (fm_oe[0]) lo_m[fm_addr] <= fm_dout[7:0];
      if (fm_oe[1]) hi_m[fm_addr] <= fm_dout[15:8];
    end
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one command, held until taken, then wait for the response
  task automatic host_op(input hfp_pkg::hfp_op_t k, input logic [15:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_word <= w;
    cmd_data <= d;
    @(posedge mclk_i);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 400);
    chk({15'h0000, rsp_valid}, 16'h0001);
    rd = rsp_data;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic t_reset();
    #1;
    for (int i = 0; i < 16; i++) chk({8'h00, ctrl_regs[i]}, {8'h00, hfp_pkg::REG_RESET});
    chk({15'h0000, i_hfp_link_if.ready}, 16'h0001);
    chk({10'h000, fm_cs, fm_we_n}, 16'h003F);
    chk({15'h0000, bus_error}, 16'h0000);
    @(posedge mclk_i);
    $display("test reset done");
  endtask

  task automatic t_regs();
    width_16 <= hfp_pkg::WIDTH_8;
    @(posedge mclk_i);
    host_op(hfp_pkg::OP_REG_WR, 16'hABC5, 1'b0, 16'h005A);
    chk({8'h00, ctrl_regs[5]}, 16'h005A);
    host_op(hfp_pkg::OP_REG_RD, 16'h0005, 1'b0, 16'h0000);
    chk({8'h00, rd[7:0]}, 16'h005A);
    width_16 <= hfp_pkg::WIDTH_16;
    @(posedge mclk_i);
    host_op(hfp_pkg::OP_REG_WR, 16'h0002, 1'b1, 16'h3412);
    chk({ctrl_regs[3], ctrl_regs[2]}, 16'h3412);
    host_op(hfp_pkg::OP_REG_RD, 16'h7FF2, 1'b1, 16'h0000);
    chk(rd, 16'h3412);
    $display("test registers done");
  endtask

  task automatic t_mem();
    logic [4:0] ecs;
    mem_size <= hfp_pkg::MEM_32K;
    @(posedge mclk_i);
    host_op(hfp_pkg::OP_MEM_WR, 16'h8006, 1'b1, 16'hBEEF);
    chk({hi_m[16'h8006], lo_m[16'h8006]}, 16'hBEEF);
    chk(last_a, 16'h8006);
    chk({11'h000, last_cs}, 16'h001D);
    host_op(hfp_pkg::OP_MEM_RD, 16'h8006, 1'b1, 16'h0000);
    chk(rd, 16'hBEEF);
    // narrow bus, every one of the eight small chips
    mem_size <= hfp_pkg::MEM_8K;
    width_16 <= hfp_pkg::WIDTH_8;
    @(posedge mclk_i);
    for (int j = 0; j < 8; j++) begin
      host_op(hfp_pkg::OP_MEM_WR, {j[2:0], 13'h0041}, 1'b0, {8'h00, 8'h10 + j[7:0]});
      ecs = (j < 5) ? ~(5'h01 << j) : 5'h1F;
      chk({11'h000, last_cs}, {11'h000, ecs});
      chk(last_a, {j != 5, j != 6, j != 7, 13'h0041});
    end
    host_op(hfp_pkg::OP_MEM_RD, 16'hC041, 1'b0, 16'h0000);
    chk({8'h00, rd[7:0]}, 16'h0016);
    $display("test memory done");
  endtask

  task automatic t_steal();
    int n;
    mem_size <= hfp_pkg::MEM_32K;
    width_16 <= hfp_pkg::WIDTH_16;
    fetch_addr <= 16'h0010;
    fetch_req <= 1'b1;
    @(posedge mclk_i);
    fork
      host_op(hfp_pkg::OP_MEM_RD, 16'h8006, 1'b1, 16'h0000);
      begin
        for (int f = 0; f < 3; f++) begin
          n = 0;
          do begin
            @(posedge mclk_i);
            #1;
            n++;
          end while (fetch_done !== 1'b1 && n < 50);
          chk(fetch_data, 16'hA510);
        end
        @(posedge mclk_i);
        fetch_req <= 1'b0;
      end
    join
    chk(rd, 16'hBEEF);
    $display("test steal done");
  endtask

  task automatic t_refuse();
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_kind <= hfp_pkg::OP_ERROR;
    @(posedge mclk_i);
    cmd_valid <= 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      #1;
      if (rsp_valid === 1'b1 || i_hfp_link_if.ready !== 1'b1) n++;
    end
    chk(n[15:0], 16'h0000);
    chk({15'h0000, bus_error}, 16'h0000);
    @(posedge mclk_i);
    $display("test refuse done");
  endtask

  initial begin
    for (int i = 0; i < 65536; i++) begin
      lo_m[i] = i[7:0];
      hi_m[i] = i[15:8] ^ 8'hA5;
    end
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_regs();
    t_mem();
    t_steal();
    t_refuse();
    // second reset after registers were written
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    results();
  end
endmodule
